/* File: icc_pkg.sv */
// Package of the internal clock source control block: register map, field layout, reset values, timing, types.
// Assumes a 125 MHz register clock and word-indexed Avalon-MM addressing.
package icc_pkg;

	// ************************************************************
	// Register indices (word address on the bus)
	// ************************************************************
	localparam logic [1:0] ICC_IDX_CTRL_ONE  = 2'h0;
	localparam logic [1:0] ICC_IDX_CTRL_TWO  = 2'h1;
	localparam logic [1:0] ICC_IDX_TRIM      = 2'h2;
	localparam logic [1:0] ICC_IDX_STAT_FINE = 2'h3;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int ICC_BIT_SOURCE_SELECT  = 6;
	localparam int ICC_BIT_REF_STOP_EN    = 0;
	localparam int ICC_BIT_BUS_DIVIDER_HI        = 7;
	localparam int ICC_BIT_BUS_DIVIDER_LO        = 6;
	localparam int ICC_BIT_LOW_POWER      = 3;
	localparam int ICC_BIT_SOURCE_STATUS  = 2;
	localparam int ICC_BIT_FINE_TRIM      = 0;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [1:0] ICC_RST_BUS_DIVIDER        = 2'h1;
	localparam logic       ICC_RST_SOURCE_SEL  = 1'h0;
	localparam logic       ICC_RST_REF_STOP_EN = 1'h0;
	localparam logic       ICC_RST_LOW_POWER   = 1'h0;
	localparam logic [7:0] ICC_POR_TRIM        = 8'h80;
	localparam logic       ICC_POR_FINE_TRIM   = 1'h0;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int ICC_CLK_PERIOD_NS   = 8;
	localparam int ICC_REF_WAKE_NS     = 1000;
	localparam int ICC_LOOP_WAKE_NS    = 1000;
	localparam int ICC_REF_WAKE_CYC    = (ICC_REF_WAKE_NS + ICC_CLK_PERIOD_NS - 1) / ICC_CLK_PERIOD_NS;
	localparam int ICC_LOOP_WAKE_CYC   = (ICC_LOOP_WAKE_NS + ICC_CLK_PERIOD_NS - 1) / ICC_CLK_PERIOD_NS;
	localparam int ICC_LOOP_MULTIPLIER = 512;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {
		ICC_MODE_ENGAGED,
		ICC_MODE_BYPASS,
		ICC_MODE_BYPASS_LP,
		ICC_MODE_STOPPED
	} icc_mode_type;

	typedef struct packed {
		logic       loop_enable;
		logic       ref_enable;
		logic [7:0] coarse_trim;
		logic       fine_trim;
	} icc_analog_type;

endpackage

/* File: icc_clock_control.sv */
// Internal clock source control: mode machine, bus divider, trim store, status and Avalon-MM registers.
// Assumes the analog reference and loop oscillators arrive as free-running asynchronous levels.
//
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns

module icc_clock_control
	import icc_pkg::*;
#(
	parameter int REF_WAKE_CYC  = ICC_REF_WAKE_CYC,
	parameter int LOOP_WAKE_CYC = ICC_LOOP_WAKE_CYC
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        por,
	input  wire logic [1:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input  wire logic        stop_request,
	input  wire logic        wake_interrupt,
	input  wire logic        reference_clock,
	input  wire logic        loop_clock,
	output icc_analog_type   analog_ctrl,
	output logic             system_clock_out,
	output logic             bus_clock_out,
	output logic             reference_clock_out,
	output logic             fixed_freq_clock,
	output logic             fixed_freq_valid,
	output logic             clock_settling
);

	// ************************************************************
	// Register state
	// ************************************************************
	logic          source_select_ff;
	logic          reference_stop_enable_ff;
	logic [1:0]    bus_divider_ff;
	logic          low_power_select_ff;
	logic [7:0]    reference_trim_ff;
	logic          fine_trim_ff;
	logic          ack_ff;
	logic [31:0]   readdata_ff;
	logic          wr_en;
	logic [7:0]    wr_byte;
	logic [7:0]    rd_byte;

	icc_mode_type  mode_ff;
	icc_mode_type  saved_mode_ff;
	icc_mode_type  nxt_mode;
	logic [15:0]   wake_cnt_ff;

	logic [2:0]    sync_ff [2];
	logic [1:0]    clean_ff;
	logic [1:0]    any_edge;
	logic [1:0]    rise_edge;
	logic [2:0]    div_cnt_ff;
	logic [2:0]    div_mask;
	logic          src_edge;
	logic [1:0]    status_pipe_ff;
	logic          system_clock_ff;
	logic          bus_clock_ff;
	logic          ref_out_ff;
	logic          fixed_ff;

	// ************************************************************
	// Avalon-MM slave: one wait cycle per access
	// ************************************************************
	assign waitrequest = (read | write) & ~ack_ff;
	assign wr_en       = write & ack_ff & byteenable[0];
	assign wr_byte     = writedata[7:0];
	assign readdata    = readdata_ff;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ack_ff <= 1'h0;
		end else begin
			ack_ff <= (read | write) & ~ack_ff;
		end
	end

	always_comb begin
		rd_byte = 8'h00;
		unique case (address)
			ICC_IDX_CTRL_ONE: begin
				rd_byte[ICC_BIT_SOURCE_SELECT] = source_select_ff;
				rd_byte[ICC_BIT_REF_STOP_EN]   = reference_stop_enable_ff;
			end
			ICC_IDX_CTRL_TWO: begin
				rd_byte[ICC_BIT_BUS_DIVIDER_HI:ICC_BIT_BUS_DIVIDER_LO] = bus_divider_ff;
				rd_byte[ICC_BIT_LOW_POWER]               = low_power_select_ff;
			end
			ICC_IDX_TRIM: begin
				rd_byte = reference_trim_ff;
			end
			ICC_IDX_STAT_FINE: begin
				rd_byte[ICC_BIT_SOURCE_STATUS] = status_pipe_ff[1];
				rd_byte[ICC_BIT_FINE_TRIM]     = fine_trim_ff;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			readdata_ff <= 32'h0000_0000;
		end else if (read & ~ack_ff) begin
			readdata_ff <= {24'h00_0000, rd_byte};
		end
	end

	// ************************************************************
	// Control registers
	// ************************************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			source_select_ff         <= ICC_RST_SOURCE_SEL;
			reference_stop_enable_ff <= ICC_RST_REF_STOP_EN;
		end else if (wr_en && address == ICC_IDX_CTRL_ONE) begin
			source_select_ff         <= wr_byte[ICC_BIT_SOURCE_SELECT];
			reference_stop_enable_ff <= wr_byte[ICC_BIT_REF_STOP_EN];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bus_divider_ff      <= ICC_RST_BUS_DIVIDER;
			low_power_select_ff <= ICC_RST_LOW_POWER;
		end else if (wr_en && address == ICC_IDX_CTRL_TWO) begin
			bus_divider_ff      <= wr_byte[ICC_BIT_BUS_DIVIDER_HI:ICC_BIT_BUS_DIVIDER_LO];
			low_power_select_ff <= wr_byte[ICC_BIT_LOW_POWER];
		end
	end

	// Trim only resets at power-on, never on the ordinary reset
	always_ff @(posedge mclk or posedge por) begin
		if (por) begin
			reference_trim_ff <= ICC_POR_TRIM;
			fine_trim_ff      <= ICC_POR_FINE_TRIM;
		end else if (wr_en && address == ICC_IDX_TRIM) begin
			reference_trim_ff <= wr_byte;
		end else if (wr_en && address == ICC_IDX_STAT_FINE) begin
			fine_trim_ff <= wr_byte[ICC_BIT_FINE_TRIM];
		end
	end

	// ************************************************************
	// Mode machine
	// ************************************************************
	always_comb begin
		nxt_mode = mode_ff;
		unique case (mode_ff)
			ICC_MODE_STOPPED: begin
				if (wake_interrupt) begin
					nxt_mode = saved_mode_ff;
				end
			end
			ICC_MODE_ENGAGED, ICC_MODE_BYPASS, ICC_MODE_BYPASS_LP: begin
				if (stop_request) begin
					nxt_mode = ICC_MODE_STOPPED;
				end else if (wr_en && address == ICC_IDX_CTRL_ONE) begin
					if (!wr_byte[ICC_BIT_SOURCE_SELECT]) begin
						nxt_mode = ICC_MODE_ENGAGED;
					end else if (low_power_select_ff) begin
						nxt_mode = ICC_MODE_BYPASS_LP;
					end else begin
						nxt_mode = ICC_MODE_BYPASS;
					end
				end else if (wr_en && address == ICC_IDX_CTRL_TWO && mode_ff != ICC_MODE_ENGAGED) begin
					nxt_mode = wr_byte[ICC_BIT_LOW_POWER] ? ICC_MODE_BYPASS_LP : ICC_MODE_BYPASS;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode_ff <= ICC_MODE_ENGAGED;
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			saved_mode_ff <= ICC_MODE_ENGAGED;
		end else if (mode_ff != ICC_MODE_STOPPED && nxt_mode == ICC_MODE_STOPPED) begin
			saved_mode_ff <= mode_ff;
		end
	end

	// System and bus clocks stay gated while the reference wakes or the loop re-acquires
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wake_cnt_ff <= 16'h0000;
		end else if (mode_ff == ICC_MODE_STOPPED && nxt_mode != ICC_MODE_STOPPED) begin
			if (!reference_stop_enable_ff) begin
				wake_cnt_ff <= 16'(REF_WAKE_CYC);
			end else if (saved_mode_ff == ICC_MODE_ENGAGED) begin
				wake_cnt_ff <= 16'(LOOP_WAKE_CYC);
			end else begin
				wake_cnt_ff <= 16'h0000;
			end
		end else if (wake_cnt_ff != 16'h0000) begin
			wake_cnt_ff <= wake_cnt_ff - 16'h0001;
		end
	end

	assign clock_settling          = (wake_cnt_ff != 16'h0000);
	assign analog_ctrl.loop_enable = (mode_ff == ICC_MODE_ENGAGED) || (mode_ff == ICC_MODE_BYPASS);
	assign analog_ctrl.ref_enable  = (mode_ff != ICC_MODE_STOPPED) || reference_stop_enable_ff;
	assign analog_ctrl.coarse_trim = reference_trim_ff;
	assign analog_ctrl.fine_trim   = fine_trim_ff;

	// ************************************************************
	// Oscillator input synchronisers
	// ************************************************************
	for (genvar g = 0; g < 2; g++) begin : g_sync
		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				sync_ff[g]  <= 3'h0;
				clean_ff[g] <= 1'h0;
			end else begin
				sync_ff[g] <= {sync_ff[g][1:0], (g == 0) ? reference_clock : loop_clock};
				if (sync_ff[g][1] == sync_ff[g][2]) begin
					clean_ff[g] <= sync_ff[g][2];
				end
			end
		end
		assign any_edge[g]  = (sync_ff[g][1] == sync_ff[g][2]) && (sync_ff[g][2] != clean_ff[g]);
		assign rise_edge[g] = any_edge[g] && sync_ff[g][2];
	end

	// ************************************************************
	// Source select, divider and output clocks
	// ************************************************************
	// Index 0 is the reference, index 1 the loop
	assign src_edge = (mode_ff != ICC_MODE_STOPPED) && !clock_settling
		&& (source_select_ff ? any_edge[0] : any_edge[1]);
	assign div_mask = {bus_divider_ff == 2'h3, bus_divider_ff[1], bus_divider_ff != 2'h0};

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			div_cnt_ff      <= 3'h0;
			system_clock_ff <= 1'h0;
		end else if (src_edge) begin
			if ((div_cnt_ff & div_mask) == div_mask) begin
				div_cnt_ff      <= 3'h0;
				system_clock_ff <= ~system_clock_ff;
			end else begin
				div_cnt_ff <= div_cnt_ff + 3'h1;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bus_clock_ff <= 1'h0;
		end else if (src_edge && (div_cnt_ff & div_mask) == div_mask && !system_clock_ff) begin
			bus_clock_ff <= ~bus_clock_ff;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			status_pipe_ff <= {2{ICC_RST_SOURCE_SEL}};
		end else if (src_edge) begin
			status_pipe_ff <= {status_pipe_ff[0], source_select_ff};
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ref_out_ff <= 1'h0;
			fixed_ff   <= 1'h0;
		end else begin
			ref_out_ff <= analog_ctrl.ref_enable & clean_ff[0];
			// Fixed clock halts in stop even while the reference keeps running
			if (rise_edge[0] && mode_ff != ICC_MODE_STOPPED) begin
				fixed_ff <= ~fixed_ff;
			end
		end
	end

	assign system_clock_out    = system_clock_ff;
	assign bus_clock_out       = bus_clock_ff;
	assign reference_clock_out = ref_out_ff;
	assign fixed_freq_clock    = fixed_ff;
	assign fixed_freq_valid    = (mode_ff == ICC_MODE_ENGAGED) && !clock_settling;

	// ************************************************************
	// Assertions
	// ************************************************************
	property p_sel_zero_engages;
		@(posedge mclk) disable iff (rst)
		(mode_ff != ICC_MODE_STOPPED && !stop_request && wr_en && address == ICC_IDX_CTRL_ONE
			&& !wr_byte[ICC_BIT_SOURCE_SELECT]) |=> (mode_ff == ICC_MODE_ENGAGED);
	endproperty
	a_sel_zero_engages: assert property (p_sel_zero_engages) else $error("select 0 did not engage loop");

	property p_bypass_entry;
		@(posedge mclk) disable iff (rst)
		(mode_ff != ICC_MODE_STOPPED && !stop_request && wr_en && address == ICC_IDX_CTRL_ONE
			&& wr_byte[ICC_BIT_SOURCE_SELECT] && !low_power_select_ff) |=> (mode_ff == ICC_MODE_BYPASS) && analog_ctrl.loop_enable;
	endproperty
	a_bypass_entry: assert property (p_bypass_entry) else $error("bypass mode not entered");

	property p_bypass_lp_entry;
		@(posedge mclk) disable iff (rst)
		(mode_ff != ICC_MODE_STOPPED && !stop_request && wr_en && address == ICC_IDX_CTRL_ONE
			&& wr_byte[ICC_BIT_SOURCE_SELECT] && low_power_select_ff) |=> !analog_ctrl.loop_enable;
	endproperty
	a_bypass_lp_entry: assert property (p_bypass_lp_entry) else $error("loop still on in low-power bypass");

	property p_stop_gating;
		@(posedge mclk) disable iff (rst)
		(mode_ff == ICC_MODE_STOPPED) |-> !analog_ctrl.loop_enable
			&& (analog_ctrl.ref_enable == reference_stop_enable_ff) && !src_edge;
	endproperty
	a_stop_gating: assert property (p_stop_gating) else $error("clocks not gated in stop");

	property p_wake_resume;
		@(posedge mclk) disable iff (rst)
		(mode_ff == ICC_MODE_STOPPED && wake_interrupt) |=> (mode_ff == $past(saved_mode_ff));
	endproperty
	a_wake_resume: assert property (p_wake_resume) else $error("wake did not resume prior mode");

	property p_ref_wake_delay;
		@(posedge mclk) disable iff (rst)
		(mode_ff == ICC_MODE_STOPPED && wake_interrupt && !reference_stop_enable_ff) |=> clock_settling[*8];
	endproperty
	a_ref_wake_delay: assert property (p_ref_wake_delay) else $error("reference wake delay too short");

	property p_divider_write;
		@(posedge mclk) disable iff (rst)
		(wr_en && address == ICC_IDX_CTRL_TWO) |=> (bus_divider_ff == $past(wr_byte[ICC_BIT_BUS_DIVIDER_HI:ICC_BIT_BUS_DIVIDER_LO]));
	endproperty
	a_divider_write: assert property (p_divider_write) else $error("divider write not taken");

	property p_status_sync;
		@(posedge mclk) disable iff (rst)
		!src_edge |=> $stable(status_pipe_ff[1]);
	endproperty
	a_status_sync: assert property (p_status_sync) else $error("status moved without source edge");

	property p_fixed_valid;
		@(posedge mclk) disable iff (rst)
		fixed_freq_valid |-> (mode_ff == ICC_MODE_ENGAGED);
	endproperty
	a_fixed_valid: assert property (p_fixed_valid) else $error("fixed clock valid outside engaged");

	property p_read_upper_zero;
		@(posedge mclk) disable iff (rst)
		(read && ack_ff) |-> (readdata[31:8] == 24'h00_0000);
	endproperty
	a_read_upper_zero: assert property (p_read_upper_zero) else $error("upper read bits not zero");

	c_enter_stop: cover property (@(posedge mclk) disable iff (rst) mode_ff != ICC_MODE_STOPPED ##1 mode_ff == ICC_MODE_STOPPED);
	c_wake: cover property (@(posedge mclk) disable iff (rst) mode_ff == ICC_MODE_STOPPED ##1 mode_ff != ICC_MODE_STOPPED);
	c_bypass_lp: cover property (@(posedge mclk) disable iff (rst) mode_ff == ICC_MODE_BYPASS_LP);

endmodule

/* File: tb.sv */
// Self-checking testbench of the internal clock source control block.
// Assumes icc_pkg compiled first; oscillator levels are made here from mclk.
`timescale 1ns/1ns
module tb;
	import icc_pkg::*;

	localparam int RWC = 12;
	localparam int LWC = 10;

	logic            mclk = 1'b0;
	logic            rst, por, read, write, stop_request, wake_interrupt;
	logic            reference_clock = 1'b0;
	logic            loop_clock = 1'b0;
	logic            waitrequest;
	logic [1:0]      address;
	logic [31:0]     writedata, readdata;
	logic [3:0]      byteenable;
	icc_analog_type  analog_ctrl;
	logic            system_clock_out, bus_clock_out, reference_clock_out;
	logic            fixed_freq_clock, fixed_freq_valid, clock_settling;
	logic [3:0]      ref_cnt_ff = 4'h0;
	logic [1:0]      loop_cnt_ff = 2'h0;
	int              err_count, total_checks;
	int              cyc = 0;

	icc_clock_control #(.REF_WAKE_CYC(RWC), .LOOP_WAKE_CYC(LWC)) i_icc_clock_control (
		.mclk(mclk), .rst(rst), .por(por), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.stop_request(stop_request), .wake_interrupt(wake_interrupt), .reference_clock(reference_clock),
		.loop_clock(loop_clock), .analog_ctrl(analog_ctrl), .system_clock_out(system_clock_out),
		.bus_clock_out(bus_clock_out), .reference_clock_out(reference_clock_out),
		.fixed_freq_clock(fixed_freq_clock), .fixed_freq_valid(fixed_freq_valid),
		.clock_settling(clock_settling));

	// ********************
	// Clock, oscillators, timeout
	// ********************
	always #4 mclk = ~mclk;

	// Reference toggles every 8 cycles, loop every 3 cycles
	always @(posedge mclk) begin
		ref_cnt_ff <= ref_cnt_ff + 4'h1;
		loop_cnt_ff <= (loop_cnt_ff == 2'h2) ? 2'h0 : loop_cnt_ff + 2'h1;
		if (ref_cnt_ff == 4'h7 || ref_cnt_ff == 4'hF) reference_clock <= ~reference_clock;
		if (loop_cnt_ff == 2'h2) loop_clock <= ~loop_clock;
		cyc <= cyc + 1;
	end

	// ********************
	// Shared tasks
	// ********************
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task bus(input logic [1:0] a, input logic wr, input logic [7:0] d, input logic be, output logic [31:0] q);
		int n;
		@(posedge mclk);
		address <= a;
		write <= wr;
		read <= !wr;
		writedata <= {24'h0, d};
		byteenable <= {3'h0, be};
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		if (n >= 50) check("waitrequest", 32'(waitrequest), 32'h0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task wr(input logic [1:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, 1'b1, q);
	endtask

	task rd(input logic [1:0] a, input logic [31:0] exp, input string name);
		logic [31:0] q;
		bus(a, 1'b0, 8'h00, 1'b0, q);
		check(name, q, exp);
	endtask

	function automatic logic sig(input int w);
		case (w)
			0: sig = system_clock_out;
			1: sig = bus_clock_out;
			2: sig = fixed_freq_clock;
			default: sig = reference_clock_out;
		endcase
	endfunction

	task edge_wait(input int w);
		int n;
		logic prev;
		n = 0;
		@(negedge mclk);
		prev = sig(w);
		do begin
			@(negedge mclk);
			n++;
			if (prev === 1'b0 && sig(w) === 1'b1) break;
			prev = sig(w);
		end while (n < 400);
	endtask

	task chk_period(input int w, input int exp, input string name);
		int c0;
		edge_wait(w);
		edge_wait(w);
		c0 = cyc;
		edge_wait(w);
		check(name, 32'(cyc - c0), 32'(exp));
	endtask

	task chk_still(input int w, input string name);
		logic s, still;
		@(negedge mclk);
		s = sig(w);
		still = 1'b1;
		repeat (40) begin
			@(negedge mclk);
			if (sig(w) !== s) still = 1'b0;
		end
		check(name, 32'(still), 32'h1);
	endtask

	task do_reset;
		@(posedge mclk);
		rst <= 1'b1;
		stop_request <= 1'b0;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
	endtask

	task stop_enter;
		@(posedge mclk);
		stop_request <= 1'b1; // Supply monitor taken as set up before stop
		repeat (2) @(negedge mclk);
	endtask

	task wake(output int n, output logic v);
		@(posedge mclk);
		stop_request <= 1'b0;
		wake_interrupt <= 1'b1;
		@(posedge mclk);
		wake_interrupt <= 1'b0;
		@(negedge mclk);
		v = fixed_freq_valid;
		n = 0;
		while (clock_settling === 1'b1 && n < 500) begin
			n++;
			@(negedge mclk);
		end
	endtask

	// ********************
	// Scenarios
	// ********************
	task s_regs;
		logic [31:0] q;
		rd(ICC_IDX_CTRL_ONE, 32'h00, "ctrl_one_rst");
		rd(ICC_IDX_CTRL_TWO, 32'h40, "ctrl_two_rst");
		rd(ICC_IDX_TRIM, 32'h80, "trim_por");
		rd(ICC_IDX_STAT_FINE, 32'h00, "stat_rst");
		wr(ICC_IDX_CTRL_ONE, 8'hBF);
		rd(ICC_IDX_CTRL_ONE, 32'h01, "ctrl_one_mask");
		wr(ICC_IDX_CTRL_TWO, 8'hB7);
		rd(ICC_IDX_CTRL_TWO, 32'h80, "ctrl_two_mask");
		wr(ICC_IDX_TRIM, 8'h3C);
		wr(ICC_IDX_STAT_FINE, 8'hFF);
		rd(ICC_IDX_STAT_FINE, 32'h01, "stat_mask");
		check("coarse", 32'(analog_ctrl.coarse_trim), 32'h3C);
		check("fine", 32'(analog_ctrl.fine_trim), 32'h1);
		bus(ICC_IDX_TRIM, 1'b1, 8'h11, 1'b0, q);
		rd(ICC_IDX_TRIM, 32'h3C, "trim_no_be");
		do_reset;
		rd(ICC_IDX_TRIM, 32'h3C, "trim_kept");
		rd(ICC_IDX_STAT_FINE, 32'h01, "fine_kept");
		rd(ICC_IDX_CTRL_ONE, 32'h00, "ctrl_one_rst2");
		rd(ICC_IDX_CTRL_TWO, 32'h40, "ctrl_two_rst2");
	endtask

	task s_modes;
		logic [31:0] q;
		int n;
		wr(ICC_IDX_CTRL_ONE, 8'h40);
		rd(ICC_IDX_STAT_FINE, 32'h01, "stat_early");
		n = 0;
		do begin
			bus(ICC_IDX_STAT_FINE, 1'b0, 8'h00, 1'b0, q);
			n++;
		end while (q[2] !== 1'b1 && n < 12);
		check("stat_ref", q, 32'h05);
		check("ff_valid_byp", 32'(fixed_freq_valid), 32'h0);
		check("loop_en_byp", 32'(analog_ctrl.loop_enable), 32'h1);
		chk_period(0, 32, "sysclk_ref");
		wr(ICC_IDX_CTRL_TWO, 8'h48);
		@(negedge mclk);
		check("loop_en_lp", 32'(analog_ctrl.loop_enable), 32'h0);
		wr(ICC_IDX_CTRL_ONE, 8'h00);
		@(negedge mclk);
		check("loop_en_fei", 32'(analog_ctrl.loop_enable), 32'h1);
		check("ff_valid_fei", 32'(fixed_freq_valid), 32'h1);
		repeat (LWC) @(posedge mclk); // Loop acquisition wait
		chk_period(0, 12, "sysclk_loop");
		chk_period(2, 32, "ffclk");
		wr(ICC_IDX_CTRL_TWO, 8'h40);
	endtask

	task s_divider;
		for (int i = 0; i < 4; i++) begin
			wr(ICC_IDX_CTRL_TWO, {i[1:0], 6'h00}); // Divider i: system clock divide-by-1, 2, 4 or 8
			chk_period(0, 6 << i, "sysclk_div");
			chk_period(1, 12 << i, "busclk_div");
		end
		wr(ICC_IDX_CTRL_TWO, 8'h40);
	endtask

	task s_stop;
		int n;
		logic v;
		wr(ICC_IDX_CTRL_ONE, 8'h01);
		stop_enter;
		check("loop_en_stop", 32'(analog_ctrl.loop_enable), 32'h0);
		check("ref_en_kept", 32'(analog_ctrl.ref_enable), 32'h1);
		chk_period(3, 16, "refclk_kept");
		chk_still(0, "sysclk_stop");
		chk_still(2, "ffclk_stop");
		wake(n, v);
		check("settle_loop", 32'(n), 32'(LWC));
		check("ff_valid_settle", 32'(v), 32'h0);
		check("ff_valid_wake", 32'(fixed_freq_valid), 32'h1);
		check("loop_en_wake", 32'(analog_ctrl.loop_enable), 32'h1);
		wr(ICC_IDX_CTRL_TWO, 8'h48);
		wr(ICC_IDX_CTRL_ONE, 8'h40);
		stop_enter;
		check("ref_en_off", 32'(analog_ctrl.ref_enable), 32'h0);
		chk_still(3, "refclk_stop");
		wake(n, v);
		check("settle_ref", 32'(n), 32'(RWC));
		check("loop_en_lp_wake", 32'(analog_ctrl.loop_enable), 32'h0);
		check("ff_valid_lp_wake", 32'(fixed_freq_valid), 32'h0);
		stop_enter;
		do_reset;
		@(negedge mclk);
		check("loop_en_rst_stop", 32'(analog_ctrl.loop_enable), 32'h1);
		check("ff_valid_rst_stop", 32'(fixed_freq_valid), 32'h1);
		rd(ICC_IDX_CTRL_ONE, 32'h00, "ctrl_one_rst_stop");
	endtask

	task results;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ********************
	// Main sequence
	// ********************
	initial begin
		rst = 1'b1;
		por = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = 2'h0;
		writedata = 32'h0;
		byteenable = 4'h0;
		stop_request = 1'b0;
		wake_interrupt = 1'b0;
		err_count = 0;
		total_checks = 0;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		por <= 1'b0;
		fork
			begin
				s_regs;
				s_modes;
				s_divider;
				s_stop;
			end
			begin
				// Cycle ceiling: a hang counts as a mismatch
				wait (cyc == 30000);
				err_count++;
			end
		join_any
		results;
	end
endmodule
